// [hdl/qdsc_top.v]
`include "qdsc_regs.vh"
`default_nettype none
module qdsc_top #(
  parameter CODE_W = 16
) (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire serial_clock_in,
  input wire chip_select_load_in,
  input wire serial_data_in,
  input wire async_load_all_in,
  input wire async_clear_in,
  input wire fixed_span_in,
  input wire span_strap_bit0_in,
  input wire span_strap_bit1_in,
  input wire span_strap_bit2_in,
  output reg serial_readback_out,
  output reg serial_readback_oe_out,
  output reg reset_flag_out,
  output reg [4*CODE_W-1:0] dac_code_out,
  output reg [4*4-1:0] dac_span_out
);
  wire [7:0] pins_s;
  wire sck_s;
  wire csl_n_s;
  wire sdi_s;
  wire async_load_all_n_s;
  wire clr_n_s;
  wire mspan_s;
  wire [2:0] strap_s;
  reg sck_d;
  reg csl_d;
  reg async_load_all_d;
  reg [31:0] shift;
  reg [5:0] bit_cnt;
  reg [1:0] ptr_ch;
  reg [1:0] ptr_sel;
  reg [CODE_W-1:0] tx;
  reg load_pending;
  reg [3:0] wr_code_en;
  reg [3:0] wr_span_en;
  reg [3:0] upd_en;
  reg [CODE_W-1:0] wr_data;
  reg clear_now;
  reg rd_en;
  reg [1:0] rd_ch;
  reg [1:0] rd_sel;
  reg aborted;
  wire [CODE_W-1:0] rd_data;
  wire [4*CODE_W-1:0] dac_code_w;
  wire [16-1:0] dac_span_w;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;
  wire [3:0] f_cmd;
  wire [2:0] f_ch;
  wire frame_ok;

  // Channel mask decode from address bits 3 to 1; used by the write, combined and update commands.
  function [3:0] qdsc_ch_mask;
    input [2:0] a;
    begin
      case (a)
        3'h0: qdsc_ch_mask = 4'h1;
        3'h1: qdsc_ch_mask = 4'h2;
        3'h2: qdsc_ch_mask = 4'h4;
        3'h3: qdsc_ch_mask = 4'h8;
        `QDSC_ADDR_ALL: qdsc_ch_mask = 4'hF;
        default: qdsc_ch_mask = 4'h0;
      endcase
    end
  endfunction

  // Readback channel; the all address reads channel A.
  function [1:0] qdsc_rd_ch;
    input [2:0] a;
    begin
      qdsc_rd_ch = (a[2]) ? 2'h0 : a[1:0];
    end
  endfunction

  // Every pin crosses into the system clock before use.
  qdsc_sync #(.WIDTH(8), .RST_VAL(8'h58)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in({serial_clock_in, chip_select_load_in, serial_data_in, async_load_all_in,
               async_clear_in, fixed_span_in, span_strap_bit1_in, span_strap_bit0_in}),
    .sync_out(pins_s)
  );

  // The third strap has its own pair so the bundle above stays a byte.
  qdsc_sync #(.WIDTH(1)) u_sync_s2 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in(span_strap_bit2_in),
    .sync_out(strap_s[2])
  );

  assign sck_s = pins_s[7];
  assign csl_n_s = pins_s[6];
  assign sdi_s = pins_s[5];
  assign async_load_all_n_s = pins_s[4];
  assign clr_n_s = pins_s[3];
  assign mspan_s = pins_s[2];
  assign strap_s[1:0] = pins_s[1:0];
  assign sck_rise = sck_s && !sck_d && !csl_n_s;
  assign sck_fall = !sck_s && sck_d && !csl_n_s;
  assign cs_rise = csl_n_s && !csl_d;
  assign frame_ok = (bit_cnt == `QDSC_FRAME_SHORT) ||
                    ((bit_cnt == `QDSC_FRAME_LONG) && (shift[31:24] == 8'h00));
  assign f_cmd = shift[23:20];
  assign f_ch = shift[19:17];

  qdsc_regfile #(.CODE_W(CODE_W)) u_regs (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .clear_in(clear_now),
    .wr_code_en_in(wr_code_en),
    .wr_span_en_in(wr_span_en),
    .wr_data_in(wr_data),
    .upd_en_in(upd_en),
    .rd_ch_in(rd_ch),
    .rd_sel_in(rd_sel),
    .rd_en_in(rd_en),
    .fixed_span_in(mspan_s),
    .strap_span_in(strap_s),
    .rd_data_out(rd_data),
    .dac_code_out(dac_code_w),
    .dac_span_out(dac_span_w)
  );

  // Shift register and bit counter on synchronised serial clock edges.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sck_d <= 1'b0;
      csl_d <= 1'b1;
      async_load_all_d <= 1'b1;
      shift <= 32'h00000000;
      bit_cnt <= 6'h00;
      aborted <= 1'b0;
    end
    else if (ce_in)
    begin
      sck_d <= sck_s;
      csl_d <= csl_n_s;
      async_load_all_d <= async_load_all_n_s;
      if (csl_n_s)
      begin
        bit_cnt <= 6'h00;
        aborted <= 1'b0;
      end
      else if (!clr_n_s)
        aborted <= 1'b1;
      else if (sck_rise)
      begin
        shift <= {shift[30:0], sdi_s};
        if (bit_cnt != 6'h3F)
          bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // Command execution at the frame end, plus clear and the load pin.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_code_en <= 4'h0;
      wr_span_en <= 4'h0;
      upd_en <= 4'h0;
      wr_data <= {CODE_W{1'b0}};
      clear_now <= 1'b0;
      ptr_ch <= 2'h0;
      ptr_sel <= `QDSC_SEL_DAC_SPAN;
      reset_flag_out <= 1'b0;
      load_pending <= 1'b0;
    end
    else if (ce_in)
    begin
      wr_code_en <= 4'h0;
      wr_span_en <= 4'h0;
      upd_en <= 4'h0;
      clear_now <= 1'b0;
      wr_data <= shift[CODE_W-1:0];
      // The pin's falling level counts once; a held low does not re-update.
      load_pending <= !async_load_all_n_s && async_load_all_d && csl_n_s;
      if (!clr_n_s)
      begin
        clear_now <= 1'b1;
        ptr_ch <= 2'h0;
        ptr_sel <= `QDSC_SEL_DAC_SPAN;
        reset_flag_out <= 1'b0;
      end
      else if (load_pending)
      begin
        upd_en <= 4'hF;
        reset_flag_out <= 1'b1;
      end
      else if (cs_rise && frame_ok && !aborted)
      begin
        case (f_cmd)
          `QDSC_CMD_WR_SPAN:
          begin
            wr_span_en <= qdsc_ch_mask(f_ch);
            ptr_sel <= `QDSC_SEL_IN_SPAN;
            ptr_ch <= qdsc_rd_ch(f_ch);
          end
          `QDSC_CMD_WR_CODE:
          begin
            wr_code_en <= qdsc_ch_mask(f_ch);
            ptr_sel <= `QDSC_SEL_IN_CODE;
            ptr_ch <= qdsc_rd_ch(f_ch);
          end
          `QDSC_CMD_UPD_CH, `QDSC_CMD_UPD_ALL, `QDSC_CMD_WSPAN_UCH, `QDSC_CMD_WCODE_UCH,
          `QDSC_CMD_WSPAN_UALL, `QDSC_CMD_WCODE_UALL:
          begin
            reset_flag_out <= 1'b1;
            if (f_cmd == `QDSC_CMD_WSPAN_UCH || f_cmd == `QDSC_CMD_WSPAN_UALL)
              wr_span_en <= qdsc_ch_mask(f_ch);
            if (f_cmd == `QDSC_CMD_WCODE_UCH || f_cmd == `QDSC_CMD_WCODE_UALL)
              wr_code_en <= qdsc_ch_mask(f_ch);
            if (f_cmd == `QDSC_CMD_UPD_ALL || f_cmd[3])
              upd_en <= 4'hF;
            else
              upd_en <= qdsc_ch_mask(f_ch);
            if (f_cmd == `QDSC_CMD_UPD_ALL)
            begin
              ptr_sel <= `QDSC_SEL_DAC_CODE;
              ptr_ch <= 2'h0;
            end
            else
            begin
              ptr_sel <= (f_cmd[0] && f_cmd != `QDSC_CMD_UPD_ALL) ? `QDSC_SEL_DAC_CODE
                                                                  : `QDSC_SEL_DAC_SPAN;
              ptr_ch <= qdsc_rd_ch(f_ch);
            end
          end
          `QDSC_CMD_NOP:
          begin
            ptr_sel <= `QDSC_SEL_DAC_CODE;
            ptr_ch <= qdsc_rd_ch(f_ch);
          end
          `QDSC_CMD_RD_IN_SPAN, `QDSC_CMD_RD_IN_CODE, `QDSC_CMD_RD_DAC_SPAN, `QDSC_CMD_RD_DAC_CODE:
          begin
            ptr_sel <= f_cmd[1:0] - 2'h2;
            ptr_ch <= qdsc_rd_ch(f_ch);
          end
          default:
          begin
            // Reserved codes leave the buffers and the pointer untouched.
            ptr_sel <= ptr_sel;
          end
        endcase
      end
    end
  end

  // Readback load request: read commands pick their buffer, others the pointer.
  always @*
  begin
    rd_en = 1'b0;
    rd_ch = ptr_ch;
    rd_sel = ptr_sel;
    if (!csl_n_s && sck_rise)
    begin
      if ((bit_cnt == 6'h07 && shift[6:3] != 4'h0) || bit_cnt == 6'h0F)
      begin
        rd_en = 1'b1;
        if (shift[6] && shift[6:5] != 2'h0 && (shift[6:3] >= `QDSC_CMD_RD_IN_SPAN) &&
            (shift[6:3] <= `QDSC_CMD_RD_DAC_CODE))
        begin
          rd_sel = shift[4:3] - 2'h2;
          rd_ch = qdsc_rd_ch({shift[2:0]});
        end
      end
    end
  end

  // Readback shifter: low before the payload, one bit per falling edge after.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx <= {CODE_W{1'b0}};
      serial_readback_out <= 1'b0;
      serial_readback_oe_out <= 1'b0;
    end
    else if (ce_in)
    begin
      serial_readback_oe_out <= !csl_n_s;
      if (csl_n_s)
      begin
        // A cut frame must not leave bits behind that would leak into the next header.
        serial_readback_out <= 1'b0;
        tx <= {CODE_W{1'b0}};
      end
      else if (sck_fall)
      begin
        if (bit_cnt == 6'h08 && shift[7:4] != 4'h0)
        begin
          tx <= {rd_data[CODE_W-2:0], 1'b0};
          serial_readback_out <= rd_data[CODE_W-1];
        end
        else if (bit_cnt == `QDSC_HEAD_LONG && shift[15:8] == 8'h00)
        begin
          tx <= {rd_data[CODE_W-2:0], 1'b0};
          serial_readback_out <= rd_data[CODE_W-1];
        end
        else if (bit_cnt > 6'h08)
        begin
          tx <= {tx[CODE_W-2:0], 1'b0};
          serial_readback_out <= tx[CODE_W-1];
        end
        else
          serial_readback_out <= 1'b0;
      end
    end
  end

  // Registered copies of the active code and range; span bit 3 is dropped.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dac_code_out <= {4*CODE_W{1'b0}};
      dac_span_out <= 16'h0000;
    end
    else if (ce_in)
    begin
      dac_code_out <= dac_code_w;
      dac_span_out <= dac_span_w & 16'h7777;
    end
  end
endmodule // qdsc_top
`default_nettype wire

// [shared/qdsc_regs.vh]
// Functional notes
// - While chip select is low, capture the data bit on each serial clock rise.
// - Frame is 24 bits MSB first: command nibble, address nibble, 16 payload bits.
// - A 32-bit frame has eight leading zeros before the normal 24-bit layout.
// - Readback output drives low until command and address nibbles are shifted in.
// - In 24-bit frames readback bits change on falling edges 8 to 23.
// - In 32-bit frames readback bits change on falling edges 16 to 31.
// - Readback output is high impedance while chip select is high.
// - Load pin low updates all channels like update-all, ignored while selected.
// - Writes only change the chosen input register, never the DAC registers.
// - Update copies code and span input registers to DAC registers together.
// - Fixed-span pin high forces all active spans from the strap pins; the code takes the straps only at a channel's update.
// - Command nibble decodes write, update, combined, read, no-op; others are reserved.
// - Read commands pick a buffer and shift it out within the same frame.
// - Non-read frames shift out the buffer chosen by the previous command.
// - Each command sets the readback pointer for the next frame per its kind.
// - After clear or power-up the pointer selects channel A DAC span.
// - Address bits 3 to 1 select channel A to D or all; bit 0 ignored.
// - Readback with the all-channels address returns channel A data.
// - Span readback places span bits in the last four payload bits.
// - Each channel keeps input code, DAC code, input span, DAC span, readback; the code has one readback register shared by all channels.
// - Clear zeroes DAC code and span registers but keeps the input buffers.
// - Clear during a frame aborts the frame.
// - At power-up all code and span registers reset to zero.
// - Reset flag goes low on power-up or clear, high after an update.
`ifndef QDSC_REGS_VH
`define QDSC_REGS_VH
`define QDSC_CMD_WR_SPAN 4'h2
`define QDSC_CMD_WR_CODE 4'h3
`define QDSC_CMD_UPD_CH 4'h4
`define QDSC_CMD_UPD_ALL 4'h5
`define QDSC_CMD_WSPAN_UCH 4'h6
`define QDSC_CMD_WCODE_UCH 4'h7
`define QDSC_CMD_WSPAN_UALL 4'h8
`define QDSC_CMD_WCODE_UALL 4'h9
`define QDSC_CMD_RD_IN_SPAN 4'hA
`define QDSC_CMD_RD_IN_CODE 4'hB
`define QDSC_CMD_RD_DAC_SPAN 4'hC
`define QDSC_CMD_RD_DAC_CODE 4'hD
`define QDSC_CMD_NOP 4'hF
`define QDSC_ADDR_ALL 3'h7
`define QDSC_SEL_IN_SPAN 2'h0
`define QDSC_SEL_IN_CODE 2'h1
`define QDSC_SEL_DAC_SPAN 2'h2
`define QDSC_SEL_DAC_CODE 2'h3
`define QDSC_FRAME_SHORT 6'h18
`define QDSC_FRAME_LONG 6'h20
`define QDSC_HEAD_SHORT 6'h08
`define QDSC_HEAD_LONG 6'h10
`define QDSC_SPAN_W 4
`endif

// [hdl/qdsc_sync.v]
`default_nettype none
module qdsc_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage;

  // Two flops per pin; the first stage feeds only the second.
  // Reset loads each pin's idle level, so no false edge, select or clear follows reset.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      stage <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else if (ce_in)
    begin
      stage <= async_in;
      sync_out <= stage;
    end
  end
endmodule // qdsc_sync
`default_nettype wire

// [hdl/qdsc_regfile.v]
`include "qdsc_regs.vh"
`default_nettype none
module qdsc_regfile #(
  parameter CODE_W = 16
) (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire clear_in,
  input wire [3:0] wr_code_en_in,
  input wire [3:0] wr_span_en_in,
  input wire [CODE_W-1:0] wr_data_in,
  input wire [3:0] upd_en_in,
  input wire [1:0] rd_ch_in,
  input wire [1:0] rd_sel_in,
  input wire rd_en_in,
  input wire fixed_span_in,
  input wire [2:0] strap_span_in,
  output reg [CODE_W-1:0] rd_data_out,
  output wire [4*CODE_W-1:0] dac_code_out,
  output wire [4*4-1:0] dac_span_out
);
  reg [CODE_W-1:0] in_code [0:3];
  reg [CODE_W-1:0] dac_code [0:3];
  reg [3:0] in_span [0:3];
  reg [3:0] dac_span [0:3];
  genvar g;

  // Per channel double buffers; updates copy code and span together.
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : ch
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          in_code[g] <= {CODE_W{1'b0}};
          in_span[g] <= 4'h0;
          dac_code[g] <= {CODE_W{1'b0}};
          dac_span[g] <= 4'h0;
        end
        else if (ce_in)
        begin
          if (wr_code_en_in[g])
            in_code[g] <= wr_data_in;
          if (wr_span_en_in[g])
            in_span[g] <= wr_data_in[3:0];
          if (clear_in)
          begin
            dac_code[g] <= {CODE_W{1'b0}};
            dac_span[g] <= 4'h0;
          end
          else if (upd_en_in[g])
          begin
            dac_code[g] <= wr_code_en_in[g] ? wr_data_in : in_code[g];
            if (fixed_span_in)
              dac_span[g] <= {1'b0, strap_span_in};
            else
              dac_span[g] <= wr_span_en_in[g] ? wr_data_in[3:0] : in_span[g];
          end
        end
      end
      assign dac_code_out[g*CODE_W +: CODE_W] = dac_code[g];
      assign dac_span_out[g*4 +: 4] = dac_span[g];
    end
  endgenerate

  // Readback register; span sits in the low nibble.
  always @(posedge clk_in)
  begin
    if (rst_in)
      rd_data_out <= {CODE_W{1'b0}};
    else if (ce_in && rd_en_in)
    begin
      case (rd_sel_in)
        `QDSC_SEL_IN_SPAN: rd_data_out <= {{(CODE_W-4){1'b0}}, in_span[rd_ch_in]};
        `QDSC_SEL_IN_CODE: rd_data_out <= in_code[rd_ch_in];
        `QDSC_SEL_DAC_SPAN: rd_data_out <= {{(CODE_W-4){1'b0}}, dac_span[rd_ch_in]};
        default: rd_data_out <= dac_code[rd_ch_in];
      endcase
    end
  end
endmodule // qdsc_regfile
`default_nettype wire

// [sim/qdsc_top_sva.sv]
`default_nettype none
module qdsc_chk #(
  parameter CODE_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic chip_select_load_in,
  input wire logic async_clear_in,
  input wire logic serial_readback_out,
  input wire logic serial_readback_oe_out,
  input wire logic reset_flag_out,
  input wire logic [4*CODE_W-1:0] dac_code_out,
  input wire logic [15:0] dac_span_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks share the system clock; the pins reach it through synchronisers.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_idle_release: assert property (chip_select_load_in [*8] |-> !serial_readback_oe_out)
    else $error("readback driven while deselected");
  chk_idle_low: assert property (chip_select_load_in [*8] |-> !serial_readback_out)
    else $error("readback not low while idle");
  chk_select_drive: assert property (!chip_select_load_in [*8] |-> serial_readback_oe_out)
    else $error("readback not driven in frame");
  chk_head_low: assert property ($fell(chip_select_load_in) |-> !serial_readback_out [*8])
    else $error("readback not low at frame start");
  chk_frame_stable: assert property ((!chip_select_load_in && async_clear_in) [*7] |->
    $stable(dac_code_out) && $stable(dac_span_out))
    else $error("outputs moved during a frame");
  chk_clear_zero: assert property (!async_clear_in [*6] |-> dac_code_out == '0 && dac_span_out == '0)
    else $error("clear did not zero outputs");
  chk_clear_flag: assert property (!async_clear_in [*6] |-> !reset_flag_out)
    else $error("flag high during clear");
  chk_flag_reset: assert property ($fell(rst_in) |-> !reset_flag_out)
    else $error("flag high after reset");
  chk_flag_cause: assert property ($rose(reset_flag_out) |-> chip_select_load_in && async_clear_in)
    else $error("flag rose without an update");
  chk_span_top: assert property ((dac_span_out & 16'h8888) == 16'h0000)
    else $error("span bit three set");
endmodule // qdsc_chk

bind qdsc_top qdsc_chk #(.CODE_W(CODE_W)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .chip_select_load_in(chip_select_load_in), .async_clear_in(async_clear_in),
  .serial_readback_out(serial_readback_out), .serial_readback_oe_out(serial_readback_oe_out),
  .reset_flag_out(reset_flag_out), .dac_code_out(dac_code_out), .dac_span_out(dac_span_out));
`default_nettype wire

// [sim/qdsc_host.sv]
`default_nettype none
module qdsc_host (
  input wire logic clk_in,
  input wire logic readback_in,
  output var logic serial_clock_out,
  output var logic chip_select_load_out,
  output var logic serial_data_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // The link clock rests low between frames.
  initial
  begin
    serial_clock_out = 1'b0;
    chip_select_load_out = 1'b1;
    serial_data_out = 1'b1;
  end

  // Each link clock half lasts eight system cycles; head bits must read low.
  task automatic xfer(input logic [31:0] w, input int n, output logic [15:0] rb, output logic hd);
    hd = 1'b1;
    rb = 16'h0000;
    @(posedge clk_in);
    chip_select_load_out <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_data_out <= w[i];
      repeat (8) @(posedge clk_in);
      if (i < 16)
        rb[i] = readback_in;
      else
        hd = hd & (readback_in === 1'b0);
      serial_clock_out <= 1'b1;
      repeat (8) @(posedge clk_in);
      serial_clock_out <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
    chip_select_load_out <= 1'b1;
    serial_data_out <= ~serial_data_out;
  endtask
endmodule // qdsc_host
`default_nettype wire

// [sim/tb_qdsc_top.sv]
`include "qdsc_regs.vh"
`default_nettype none
module tb_qdsc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic load_n = 1'b1;
  logic clear_n = 1'b1;
  logic fixed = 1'b0;
  logic [2:0] strap = 3'h0;
  wire sck, csn, sdi, rb_d, rb_oe, flag;
  wire [63:0] code;
  wire [15:0] span;
  wire rb_line = rb_oe ? rb_d : 1'bz;
  int error_cnt = 0;
  int total_checks = 0;
  integer seed = 32'h1E6B1A67;
  logic [15:0] icode [4], dcode [4];
  logic [3:0] ispan [4], dspan [4];
  logic [1:0] pch, psel;
  logic eflag;
  logic [3:0] cmds [13] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};

  always #5 clk_in = ~clk_in;

  qdsc_top #(.CODE_W(16)) DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .serial_clock_in(sck),
    .chip_select_load_in(csn), .serial_data_in(sdi), .async_load_all_in(load_n), .async_clear_in(clear_n),
    .fixed_span_in(fixed), .span_strap_bit0_in(strap[0]), .span_strap_bit1_in(strap[1]),
    .span_strap_bit2_in(strap[2]), .serial_readback_out(rb_d), .serial_readback_oe_out(rb_oe),
    .reset_flag_out(flag), .dac_code_out(code), .dac_span_out(span));

  qdsc_host host (.clk_in(clk_in), .readback_in(rb_line), .serial_clock_out(sck),
    .chip_select_load_out(csn), .serial_data_out(sdi));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] pick(input logic [1:0] ch, input logic [1:0] sel);
    case (sel)
      `QDSC_SEL_IN_SPAN: pick = {12'h000, ispan[ch]};
      `QDSC_SEL_IN_CODE: pick = icode[ch];
      `QDSC_SEL_DAC_SPAN: pick = {12'h000, dspan[ch]};
      default: pick = dcode[ch];
    endcase
  endfunction

  // Copy input buffers to the active ones; fixed mode takes the straps for the span instead.
  task automatic upd(input logic [3:0] m);
    for (int c = 0; c < 4; c++)
      if (m[c])
      begin
        dcode[c] = icode[c];
        dspan[c] = fixed ? {1'b0, strap} : {1'b0, ispan[c][2:0]};
      end
    eflag = 1'b1;
  endtask

  // Outputs are compared once the command has had time to land.
  task automatic post;
    repeat (10) @(posedge clk_in);
    for (int c = 0; c < 4; c++)
    begin
      check(code[c*16 +: 16], dcode[c]);
      check(span[c*4 +: 4], dspan[c]);
    end
    check(flag, eflag);
  endtask

  task automatic run(input logic [3:0] cmd, input logic [3:0] adr, input logic [15:0] pay, input int n);
    logic [15:0] rb, exp;
    logic hd;
    logic [1:0] ch;
    logic [3:0] m;
    ch = (adr[3:1] == `QDSC_ADDR_ALL) ? 2'h0 : adr[2:1];
    m = (adr[3:1] == `QDSC_ADDR_ALL) ? 4'hF : 4'h1 << ch;
    exp = (cmd >= 4'hA && cmd <= 4'hD) ? pick(ch, cmd[1:0] - 2'h2) : pick(pch, psel);
    host.xfer({8'h00, cmd, adr, pay}, n, rb, hd);
    check(rb, exp);
    check(hd, 1'b1);
    for (int c = 0; c < 4; c++)
    begin
      if (m[c] && cmd inside {4'h2, 4'h6, 4'h8})
        ispan[c] = pay[3:0];
      if (m[c] && cmd inside {4'h3, 4'h7, 4'h9})
        icode[c] = pay;
    end
    if (cmd inside {4'h5, 4'h8, 4'h9})
      upd(4'hF);
    if (cmd inside {4'h4, 4'h6, 4'h7})
      upd(m);
    pch = (cmd == 4'h5) ? 2'h0 : ch;
    case (cmd)
      4'h2: psel = 2'h0;
      4'h3: psel = 2'h1;
      4'h4, 4'h6, 4'h8: psel = 2'h2;
      4'hA, 4'hB, 4'hC, 4'hD: psel = cmd[1:0] - 2'h2;
      default: psel = 2'h3;
    endcase
    post;
  endtask

  // Reserved addresses are avoided; span payloads stay in the six defined ranges.
  task automatic rnd_run(input logic [3:0] cmd);
    logic [31:0] r;
    logic [2:0] a;
    r = $random(seed);
    a = (r[2:0] > 3'h3) ? 3'h7 : r[2:0];
    if (cmd inside {4'h2, 4'h6, 4'h8})
      r[31:16] = {13'h0000, r[18:16] % 3'h6};
    run(cmd, {a, r[3]}, r[31:16], r[4] ? 32 : 24);
  endtask

  initial
  begin
    logic [31:0] r;
    logic [15:0] rb;
    logic hd;
    for (int c = 0; c < 4; c++)
    begin
      icode[c] = 16'h0000;
      dcode[c] = 16'h0000;
      ispan[c] = 4'h0;
      dspan[c] = 4'h0;
    end
    pch = 2'h0;
    psel = `QDSC_SEL_DAC_SPAN;
    eflag = 1'b0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    post;
    run(4'hF, 4'h0, 16'h0000, 24);
    for (int k = 0; k < 13; k++)
      rnd_run(cmds[k]);
    for (int i = 0; i < 30; i++)
    begin
      if (i % 10 == 0)
      begin
        r = $random(seed);
        fixed <= r[0];
        strap <= r[3:1];
      end
      r = $random(seed);
      rnd_run(cmds[r[7:0] % 13]);
    end
    fixed <= 1'b0;
    $display("test commands done");
    run(4'h3, 4'h2, 16'hA5C3, 24);
    fork
      run(4'hF, 4'h2, 16'h0000, 24);
      begin
        repeat (100) @(posedge clk_in);
        load_n <= 1'b0;
        repeat (6) @(posedge clk_in);
        load_n <= 1'b1;
      end
    join
    load_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    load_n <= 1'b1;
    upd(4'hF);
    post;
    $display("test load pin done");
    clear_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    clear_n <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      dcode[c] = 16'h0000;
      dspan[c] = 4'h0;
    end
    pch = 2'h0;
    psel = `QDSC_SEL_DAC_SPAN;
    eflag = 1'b0;
    post;
    run(4'h5, 4'hE, 16'h0000, 24);
    // A clear inside a frame clears the active registers and drops the write.
    fork
      host.xfer({8'h00, 8'h36, 16'h1234}, 24, rb, hd);
      begin
        repeat (100) @(posedge clk_in);
        clear_n <= 1'b0;
        repeat (8) @(posedge clk_in);
        clear_n <= 1'b1;
      end
    join
    for (int c = 0; c < 4; c++)
    begin
      dcode[c] = 16'h0000;
      dspan[c] = 4'h0;
    end
    pch = 2'h0;
    psel = `QDSC_SEL_DAC_SPAN;
    eflag = 1'b0;
    post;
    $display("test clear done");
    host.xfer({8'h5A, 8'h30, 16'hFFFF}, 32, rb, hd);
    post;
    host.xfer(32'h0003FFFF, 20, rb, hd);
    post;
    run(4'hB, 4'h0, 16'h0000, 32);
    $display("test refused frames done");
    wrap_up;
  end

  // Cut a hang short well beyond the expected run length.
  initial
  begin
    repeat (100000) @(posedge clk_in);
    error_cnt++;
    wrap_up;
  end
endmodule // tb_qdsc_top
`default_nettype wire
